// ==== verilog/adc_port_pkg.sv ====
// constants for the converter serial host port
package adc_port_pkg;
    localparam logic [2:0] REG_COMM   = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_FILTER = 3'h2;
    localparam logic [2:0] REG_CONFIG = 3'h1;
    localparam logic [2:0] REG_DATA   = 3'h3;
    localparam int COMM_RW_BIT  = 6;
    localparam int COMM_REG_LSB = 0;
    localparam int STATUS_RDY_BIT = 7;
    localparam int CFG_CH_LSB   = 12;
    localparam int RESET_ONES   = 32;
    localparam logic [23:0] CONFIG_RESET = 24'h000000;
    localparam logic [7:0]  FILTER_RESET = 8'h45;
    localparam logic [7:0]  FILTER_MIN   = 8'h0D;
    localparam int CLK_HZ       = 20000000;
    // period per filter step in ns: 186.77 ms / 255
    localparam int STEP_NS      = 732431;
    localparam int CLK_NS       = 50;
    localparam int STEP_CYCLES  = STEP_NS / CLK_NS;
    localparam int SETTLE_RESULTS = 3;
endpackage

// ==== verilog/adc_serial_host_port.sv ====
// serial host port: link-side shifter plus result timer in the system domain
`timescale 1ns/1ps
module adc_serial_host_port #(
    parameter int STEP_CYC = adc_port_pkg::STEP_CYCLES
) (
    input  wire logic        clock_in,
    input  wire logic        nrst_in,
    input  wire logic        sclk_in,
    input  wire logic        cs_n_in,
    input  wire logic        din_in,
    input  wire logic [15:0] sample_in,
    output logic             dout_out,
    output logic             dout_oe_out,
    output logic             ready_n_out,
    output logic [2:0]       channel_out
);
    // ---------------- link domain (sclk, mode 3: shift out on fall, sample on rise)
    typedef enum logic [1:0] {ST_COMM, ST_WRITE, ST_READ} phase_t;
    phase_t      phase_reg;
    logic [4:0]  bit_cnt_reg;
    logic [4:0]  len_reg;
    logic [23:0] shin_reg;
    logic [23:0] shout_reg;
    logic [2:0]  target_reg;
    logic [5:0]  ones_reg;
    logic [23:0] config_reg;
    logic [7:0]  filter_reg;
    logic        read_done_tgl_reg;
    logic        cfg_tgl_reg;
    logic        drive_reg;
    logic [15:0] result_hold_reg;
    logic        rdy_s1_reg;
    logic        rdy_s2_reg;
    logic        link_rst_n;
    // word captured at the comm byte so mid-read updates cannot tear it
    logic [23:0] read_word_hold;
    // result word held in the system domain, read by the link side while stable
    logic [15:0] result_sys_reg;
    wire  [23:0] shin_next   = {shin_reg[22:0], din_in};
    wire         last_bit    = (bit_cnt_reg == len_reg - 5'd1);
    // only a selected clock counts, so a stale count cannot fire while idle
    wire         ones_full   = (ones_reg == 6'(adc_port_pkg::RESET_ONES - 1)) && din_in
                               && !cs_n_in;
    wire  [2:0]  comm_target = shin_next[2:0];
    wire         comm_read   = shin_next[adc_port_pkg::COMM_RW_BIT];
    wire [4:0]   reg_len     = (comm_target == adc_port_pkg::REG_CONFIG) ? 5'd24 :
                               (comm_target == adc_port_pkg::REG_DATA)   ? 5'd16 : 5'd8;
    wire  [7:0]  status_word = {rdy_s2_reg, 7'h00};
    wire  [23:0] read_word   = (comm_target == adc_port_pkg::REG_CONFIG) ? config_reg :
                               (comm_target == adc_port_pkg::REG_DATA)
                                   ? {result_hold_reg, 8'h00} :
                               (comm_target == adc_port_pkg::REG_FILTER)
                                   ? {filter_reg, 16'h0000} : {status_word, 16'h0000};
    // system reset used directly, not gated through cs (asynchronous constants only)
    assign link_rst_n = nrst_in;
    // sampling on rising sclk; ones counter sees every selected clock
    always_ff @(posedge sclk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            phase_reg <= ST_COMM;
            bit_cnt_reg <= 5'd0;
            len_reg <= 5'd8;
            shin_reg <= 24'h000000;
            target_reg <= 3'h0;
            ones_reg <= 6'd0;
            config_reg <= adc_port_pkg::CONFIG_RESET;
            filter_reg <= adc_port_pkg::FILTER_RESET;
            read_done_tgl_reg <= 1'b0;
            cfg_tgl_reg <= 1'b0;
        end else if (ones_full) begin
            phase_reg <= ST_COMM;
            bit_cnt_reg <= 5'd0;
            len_reg <= 5'd8;
            ones_reg <= 6'd0;
            config_reg <= adc_port_pkg::CONFIG_RESET;
            filter_reg <= adc_port_pkg::FILTER_RESET;
        end else if (!cs_n_in) begin
            // ones run counted in every phase, else a 0xFF comm byte would hide it
            ones_reg <= din_in ? ones_reg + 6'd1 : 6'd0;
            if (phase_reg != ST_READ) begin
                shin_reg <= shin_next;
            end
            bit_cnt_reg <= last_bit ? 5'd0 : bit_cnt_reg + 5'd1;
            if (last_bit) begin
                case (phase_reg)
                    ST_COMM: begin
                        target_reg <= comm_target;
                        len_reg <= reg_len;
                        phase_reg <= comm_read ? ST_READ : ST_WRITE;
                    end
                    ST_WRITE: begin
                        len_reg <= 5'd8;
                        phase_reg <= ST_COMM;
                        if (target_reg == adc_port_pkg::REG_CONFIG) begin
                            config_reg <= shin_next;
                            cfg_tgl_reg <= ~cfg_tgl_reg;
                        end
                        if (target_reg == adc_port_pkg::REG_FILTER) begin
                            filter_reg <= (shin_next[7:0] < adc_port_pkg::FILTER_MIN)
                                          ? adc_port_pkg::FILTER_MIN : shin_next[7:0];
                        end
                    end
                    ST_READ: begin
                        len_reg <= 5'd8;
                        phase_reg <= ST_COMM;
                        if (target_reg == adc_port_pkg::REG_DATA) begin
                            read_done_tgl_reg <= ~read_done_tgl_reg;
                        end
                    end
                    default: phase_reg <= ST_COMM;
                endcase
            end
        end
    end
    // output shift on falling sclk; loads at the comm byte's end
    always_ff @(negedge sclk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            shout_reg <= 24'h000000;
            drive_reg <= 1'b0;
        end else if (cs_n_in) begin
            drive_reg <= 1'b0;
        end else if (phase_reg == ST_READ && bit_cnt_reg == 5'd0 && !drive_reg) begin
            shout_reg <= read_word_hold;
            drive_reg <= 1'b1;
        end else if (phase_reg == ST_READ) begin
            shout_reg <= {shout_reg[22:0], 1'b0};
        end else begin
            drive_reg <= 1'b0;
        end
    end
    // read word latched on the last comm bit
    always_ff @(posedge sclk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            read_word_hold <= 24'h000000;
        end else if (!cs_n_in && phase_reg == ST_COMM && last_bit) begin
            read_word_hold <= read_word;
        end
    end
    assign dout_out = drive_reg ? shout_reg[23] : 1'b0;
    assign dout_oe_out = drive_reg & ~cs_n_in;
    // ready level from system domain, two flops
    always_ff @(posedge sclk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rdy_s1_reg <= 1'b0;
            rdy_s2_reg <= 1'b0;
        end else begin
            rdy_s1_reg <= ~ready_n_out;
            rdy_s2_reg <= rdy_s1_reg;
        end
    end
    // result word: follows the system word while synchronised ready is inactive, stable while ready low
    always_ff @(posedge sclk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            result_hold_reg <= 16'h0000;
        end else if (!rdy_s2_reg) begin
            result_hold_reg <= result_sys_reg;
        end
    end
    // ---------------- system domain: result timer and ready pin
    logic [2:0]  rd_sync_reg;
    logic [2:0]  cfg_sync_reg;
    logic [31:0] tick_reg;
    logic [7:0]  step_reg;
    logic [1:0]  settle_reg;
    wire         rd_pulse   = rd_sync_reg[2] ^ rd_sync_reg[1];
    wire         cfg_pulse  = cfg_sync_reg[2] ^ cfg_sync_reg[1];
    wire         tick_end   = (tick_reg == 32'(STEP_CYC - 1));
    // period is filter word times step
    wire         period_end = tick_end && (step_reg == filter_reg);
    // quasi-static config/filter: only config register writes are signalled by cfg toggle crossing
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_sync_reg <= 3'b000;
            cfg_sync_reg <= 3'b000;
            tick_reg <= 32'd0;
            step_reg <= 8'd1;
            settle_reg <= 2'd0;
            result_sys_reg <= 16'h0000;
            ready_n_out <= 1'b1;
            channel_out <= 3'b000;
        end else begin
            rd_sync_reg <= {rd_sync_reg[1:0], read_done_tgl_reg};
            cfg_sync_reg <= {cfg_sync_reg[1:0], cfg_tgl_reg};
            tick_reg <= tick_end ? 32'd0 : tick_reg + 32'd1;
            if (tick_end) begin
                step_reg <= period_end ? 8'd1 : step_reg + 8'd1;
            end
            channel_out <= config_reg[adc_port_pkg::CFG_CH_LSB +: 3];
            if (cfg_pulse) begin
                settle_reg <= 2'(adc_port_pkg::SETTLE_RESULTS);
                ready_n_out <= 1'b1;
            end else if (period_end) begin
                if (settle_reg != 2'd0) begin
                    settle_reg <= settle_reg - 2'd1;
                end else begin
                    result_sys_reg <= sample_in;
                    ready_n_out <= 1'b0;
                end
            end else if (tick_end && step_reg == filter_reg - 8'd1) begin
                ready_n_out <= 1'b1;
            end else if (rd_pulse) begin
                ready_n_out <= 1'b1;
            end
        end
    end
    // status flag read via status_word from synchronised ready
    // ---------------- checks
    property p_ready_after_cfg;
        @(posedge clock_in) disable iff (!nrst_in)
        cfg_pulse |=> ready_n_out;
    endproperty
    a_ready_after_cfg: assert property (p_ready_after_cfg) else $error("ready low after cfg");
    property p_ready_after_read;
        @(posedge clock_in) disable iff (!nrst_in)
        rd_pulse && !period_end && !cfg_pulse |=> ready_n_out;
    endproperty
    a_ready_after_read: assert property (p_ready_after_read) else $error("ready stuck");
    property p_no_drive_write;
        @(posedge sclk_in) disable iff (!nrst_in)
        phase_reg == ST_WRITE |-> !dout_oe_out;
    endproperty
    a_no_drive_write: assert property (p_no_drive_write) else $error("drove in write");
    property p_ones_reset;
        @(posedge sclk_in) disable iff (!nrst_in)
        ones_full |=> phase_reg == ST_COMM && config_reg == adc_port_pkg::CONFIG_RESET;
    endproperty
    a_ones_reset: assert property (p_ones_reset) else $error("ones reset missed");

    // output must be released from the second comm bit on
    property p_release_comm;
        @(posedge sclk_in) disable iff (!nrst_in)
        phase_reg == ST_COMM && bit_cnt_reg != 5'd0 |-> !dout_oe_out;
    endproperty
    a_release_comm: assert property (p_release_comm) else $error("drove in comm");

    // shift-in register frozen while reading
    property p_read_no_shift;
        @(posedge sclk_in) disable iff (!nrst_in)
        !cs_n_in && phase_reg == ST_READ && !ones_full |=> shin_reg == $past(shin_reg);
    endproperty
    a_read_no_shift: assert property (p_read_no_shift) else $error("shifted in read");

    // a result instant inside settling leaves ready untouched
    property p_settle_hold;
        @(posedge clock_in) disable iff (!nrst_in)
        period_end && settle_reg != 2'd0 && !cfg_pulse |=> $stable(ready_n_out);
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("ready moved in settle");

    // settled result instant loads the word and lowers ready
    property p_result_load;
        @(posedge clock_in) disable iff (!nrst_in)
        period_end && settle_reg == 2'd0 && !cfg_pulse
            |=> !ready_n_out && result_sys_reg == $past(sample_in);
    endproperty
    a_result_load: assert property (p_result_load) else $error("result not loaded");

    // ready raised one step ahead of the update
    property p_rise_before_update;
        @(posedge clock_in) disable iff (!nrst_in)
        tick_end && step_reg == filter_reg - 8'd1 && !cfg_pulse |=> ready_n_out;
    endproperty
    a_rise_before_update: assert property (p_rise_before_update) else $error("no early rise");

    // channel pins follow the config field one clock later
    property p_channel_follow;
        @(posedge clock_in) disable iff (!nrst_in)
        1'b1 |=> channel_out == $past(config_reg[adc_port_pkg::CFG_CH_LSB +: 3]);
    endproperty
    a_channel_follow: assert property (p_channel_follow) else $error("channel lag");

    // main scenarios seen
    c_read: cover property (@(posedge sclk_in) phase_reg == ST_READ && dout_oe_out);
    c_ready: cover property (@(posedge clock_in) $fell(ready_n_out));
    c_cfg: cover property (@(posedge clock_in) cfg_pulse);
    c_ones: cover property (@(posedge sclk_in) ones_full);
endmodule

// ==== sim/spi_master_model.sv ====
// serial master model standing in for the host controller
`timescale 1ns/1ps
module spi_master_model (
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      din_out,
    input  wire logic dout_in,
    input  wire logic dout_oe_in
);
    int write_drive_seen;
    // data-out wire has a pull-up, so a released line reads high
    wire line_level = dout_oe_in ? dout_in : 1'b1;

    initial begin
        sclk_out = 1'b1;
        cs_n_out = 1'b1;
        din_out = 1'b1;
        write_drive_seen = 0;
    end

    task automatic xfer(input logic [7:0] comm, input int nbits,
                        input logic [23:0] wdata, output logic [23:0] rdata);
        logic [31:0] word;
        logic        rd;
        word = {comm, wdata << (24 - nbits)};
        rd = comm[6];
        rdata = 24'h000000;
        // select held over the whole frame; binds frame-sync hosts only
        cs_n_out = 1'b0;
        #3;
        for (int i = 0; i < 8 + nbits; i++) begin
            sclk_out = 1'b0;
            // din toggles while reading, the port must ignore it
            din_out = (rd && i >= 8) ? i[0] : word[31 - i];
            #3;
            sclk_out = 1'b1;
            if (rd && i >= 8) begin
                rdata = {rdata[22:0], line_level};
            end else if (dout_oe_in) begin
                // any drive while bits flow in is counted
                write_drive_seen++;
            end
            #3;
        end
        cs_n_out = 1'b1;
        // released line shows the inverse, not a stale value
        din_out = ~din_out;
    endtask

    // a run of ones to recover a lost port
    task automatic ones(input int n);
        cs_n_out = 1'b0;
        din_out = 1'b1;
        repeat (n) begin
            #3;
            sclk_out = 1'b0;
            #3;
            sclk_out = 1'b1;
        end
        #3;
        cs_n_out = 1'b1;
    endtask
endmodule

// ==== sim/adc_serial_host_port_test.sv ====
// self-checking bench for the converter serial host port
`timescale 1ns/1ps
module adc_serial_host_port_test;
    typedef struct { logic [23:0] cfg; logic [2:0] ch; } row_t;
    logic        clock_in;
    logic        nrst_in;
    logic        sclk;
    logic        cs_n;
    logic        din;
    logic        dout;
    logic        dout_oe;
    logic        ready_n;
    logic [15:0] sample_in;
    logic [2:0]  channel;
    logic [23:0] rd;
    int          fail_count;
    int          checks;
    int          cycles;
    // config words with the channel field they should select
    row_t        rows [4] = '{'{24'h001000, 3'h1}, '{24'h003000, 3'h3},
                              '{24'h005ABC, 3'h5}, '{24'h000FFF, 3'h0}};

    // short step keeps result periods to a few hundred cycles
    adc_serial_host_port #(.STEP_CYC(4)) adc_serial_host_port_inst (
        .clock_in(clock_in), .nrst_in(nrst_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .din_in(din), .sample_in(sample_in), .dout_out(dout),
        .dout_oe_out(dout_oe), .ready_n_out(ready_n), .channel_out(channel));

    spi_master_model spi_master_model_inst (
        .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din),
        .dout_in(dout), .dout_oe_in(dout_oe));

    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // hang guard, well above the expected run
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    initial begin
        nrst_in = 1'b0;
        sample_in = 16'hA5C3;
        fail_count = 0;
        checks = 0;
        cycles = 0;
        repeat (10) @(negedge clock_in);
        check(24'(ready_n), 24'h000001);
        check(24'(dout_oe), 24'h000000);
        nrst_in = 1'b1;
        repeat (4) @(negedge clock_in);
        foreach (rows[i]) begin
            spi_master_model_inst.xfer(8'h01, 24, rows[i].cfg, rd);
            repeat (4) @(negedge clock_in);
            check(24'(channel), 24'(rows[i].ch));
            spi_master_model_inst.xfer(8'h41, 24, 24'h000000, rd);
            check(rd, rows[i].cfg);
            @(negedge clock_in);
        end
        spi_master_model_inst.xfer(8'h02, 8, 24'h00000D, rd);
        // wait a bounded time for a settled result
        for (int n = 0; n < 3000 && ready_n !== 1'b0; n++) @(negedge clock_in);
        check(24'(ready_n), 24'h000000);
        spi_master_model_inst.xfer(8'h40, 8, 24'h000000, rd);
        check(24'(rd[7]), 24'h000001);
        spi_master_model_inst.xfer(8'h43, 16, 24'h000000, rd);
        check(rd, 24'(sample_in));
        repeat (4) @(negedge clock_in);
        check(24'(ready_n), 24'h000001);
        check(24'(dout_oe), 24'h000000);
        check(24'(spi_master_model_inst.write_drive_seen), 24'h000000);
        spi_master_model_inst.xfer(8'h01, 24, 24'h005000, rd);
        spi_master_model_inst.ones(32);
        repeat (4) @(negedge clock_in);
        check(24'(channel), 24'h000000);
        spi_master_model_inst.xfer(8'h42, 8, 24'h000000, rd);
        check(rd, 24'h000045);
        tally_and_finish();
    end
endmodule
